// *** design/pcd_pkg.sv ***
// Purpose: Shared constants and types of the position calibration datapath
// Assumes: 20 MHz system clock, word-addressed register port
// Notes:   Register offsets are word indices on the plain register port
// Contract
// R1: Arctangent of receiver channels gives spatial angle
// R2: Calibrated equals (angle minus zero offset) times slope
// R3: Slope factor never exceeds four
// R4: Subtract coil compensation, limited to 252 counts
// R5: Raw sine and cosine values are readable
// R6: Offset and slope first, then linearization
// R7: Neutral offset and unity slope pass angle unchanged
// R8: Neutral offset 2400h linear, 0000h wraparound; unity 0400h
// R9: Zero offset word encoding around 8192 base
// R10: Slope word fixed point, 1024 means one
// R11: Slope bit 12 inverts direction, max reference
// R12: Correction points every 8192 counts
// R13: Correction unit weighs 32 position counts
// R14: Correction factors signed within plus minus 127
// R15: Linear interpolation between adjacent correction points
// R16: Saturate positions to 0..65535, never wrap
`default_nettype none

package pcd_pkg;
	// ==========================================================
	// Widths and register map
	localparam int unsigned DW = 16;
	localparam int unsigned AW = 5;
	localparam int unsigned CW = 20;
	localparam int unsigned CORR_N = 9;
	localparam logic [AW-1:0] ADR_ZERO_OFS = 5'h00;
	localparam logic [AW-1:0] ADR_SLOPE = 5'h01;
	localparam logic [AW-1:0] ADR_COIL_SIN = 5'h02;
	localparam logic [AW-1:0] ADR_COIL_COS = 5'h03;
	localparam logic [AW-1:0] ADR_CORR_FIRST = 5'h04;
	localparam logic [AW-1:0] ADR_CORR_LAST = 5'h0c;
	localparam logic [AW-1:0] ADR_MODE = 5'h0d;
	localparam logic [AW-1:0] ADR_RAW_SIN = 5'h10;
	localparam logic [AW-1:0] ADR_RAW_COS = 5'h11;
	localparam logic [AW-1:0] ADR_SPA = 5'h12;
	localparam logic [AW-1:0] ADR_CAL = 5'h13;
	localparam logic [AW-1:0] ADR_LIN = 5'h14;
	localparam logic [AW-1:0] ADR_STATUS = 5'h15;

	// ==========================================================
	// Field layouts and encodings
	localparam logic [DW-1:0] ZERO_OFS_RST = 16'h2400;
	localparam logic [DW-1:0] ZERO_OFS_WRAP_NEUTRAL = 16'h0000;
	localparam logic [DW-1:0] SLOPE_RST = 16'h0400;
	localparam int unsigned ZO_SEL_BIT = 13;
	localparam int unsigned ZO_SCALE_SH = 5;
	localparam logic signed [21:0] HALF_SCALE = 22'sh008000;
	localparam int unsigned SLOPE_INV_BIT = 12;
	localparam int unsigned SLOPE_MAG_W = 12;
	localparam int unsigned SLOPE_FRAC = 10;
	localparam int unsigned MODE_WRAP_BIT = 0;
	localparam logic signed [DW-1:0] COIL_MAX = 16'sh00fc;
	localparam logic signed [DW-1:0] CORR_MAX = 16'sh007f;
	localparam int unsigned SEG_SH = 13;
	localparam int unsigned CORR_SCALE_SH = 5;
	localparam logic signed [35:0] POS_MAX = 36'sh00000ffff;
	localparam logic [3:0] CORDIC_LAST = 4'hf;
	localparam logic [DW-1:0] ANG_HALF = 16'h8000;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ATAN = 4'b0010,
		ST_CAL = 4'b0100,
		ST_LIN = 4'b1000
	} pcd_state_e;

	typedef struct packed {
		logic signed [DW-1:0] sin;
		logic signed [DW-1:0] cos;
	} pcd_raw_s;

	typedef struct packed {
		logic busy;
		logic done;
		logic [3:0] it;
		logic signed [CW-1:0] x;
		logic signed [CW-1:0] y;
		logic [DW-1:0] z;
	} pcd_atan_s;

	typedef struct packed {
		pcd_state_e st;
		logic [DW-1:0] zero_ofs;
		logic [DW-1:0] slope;
		logic signed [8:0] coil_sin;
		logic signed [8:0] coil_cos;
		logic [CORR_N-1:0][7:0] corr;
		logic wrap;
		pcd_raw_s raw;
		logic [DW-1:0] spa;
		logic [DW-1:0] cal;
		logic [DW-1:0] lin;
		logic vld;
		logic [DW-1:0] rdata;
	} pcd_main_s;

	localparam pcd_main_s MAIN_RST = '{st: ST_IDLE, zero_ofs: ZERO_OFS_RST, slope: SLOPE_RST,
		coil_sin: '0, coil_cos: '0, corr: '0, wrap: 1'b0, raw: '0, spa: '0, cal: '0,
		lin: '0, vld: 1'b0, rdata: '0};
endpackage

`default_nettype wire

// *** design/pcd_atan.sv ***
// Purpose: Iterative vectoring arctangent, one micro-rotation per clock
// Assumes: Start only while idle; inputs stable in the start cycle only
// Notes:   Angle scale is 65536 counts per full turn
`default_nettype none

module pcd_atan (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// Request
	input wire logic i_start,
	input wire logic signed [pcd_pkg::DW:0] i_x,
	input wire logic signed [pcd_pkg::DW:0] i_y,
	// Result
	output logic o_done,
	output logic [pcd_pkg::DW-1:0] o_angle
);
	import pcd_pkg::*;

	pcd_atan_s r_r;
	pcd_atan_s r_nxt;

	// ==========================================================
	// Angle table, atan(2^-i) in turn counts
	function automatic logic [DW-1:0] atan_lut(input logic [3:0] i);
		case (i)
			4'h0: return 16'h2000;
			4'h1: return 16'h12e4;
			4'h2: return 16'h09fb;
			4'h3: return 16'h0511;
			4'h4: return 16'h028b;
			4'h5: return 16'h0146;
			4'h6: return 16'h00a3;
			4'h7: return 16'h0051;
			4'h8: return 16'h0029;
			4'h9: return 16'h0014;
			4'ha: return 16'h000a;
			4'hb: return 16'h0005;
			4'hc: return 16'h0003;
			4'hd: return 16'h0001;
			4'he: return 16'h0001;
			default: return 16'h0000;
		endcase
	endfunction

	// ==========================================================
	// Rotation step; left half plane is folded first so the loop converges
	always_comb begin
		r_nxt = r_r;
		r_nxt.done = 1'b0;
		if (!r_r.busy && i_start) begin
			r_nxt.busy = 1'b1;
			r_nxt.it = '0;
			if (i_x < 0) begin
				r_nxt.x = -CW'(i_x);
				r_nxt.y = -CW'(i_y);
				r_nxt.z = ANG_HALF;
			end else begin
				r_nxt.x = CW'(i_x);
				r_nxt.y = CW'(i_y);
				r_nxt.z = '0;
			end
		end else if (r_r.busy) begin
			if (r_r.y >= 0) begin
				r_nxt.x = r_r.x + (r_r.y >>> r_r.it);
				r_nxt.y = r_r.y - (r_r.x >>> r_r.it);
				r_nxt.z = r_r.z + atan_lut(r_r.it); // [R1]
			end else begin
				r_nxt.x = r_r.x - (r_r.y >>> r_r.it);
				r_nxt.y = r_r.y + (r_r.x >>> r_r.it);
				r_nxt.z = r_r.z - atan_lut(r_r.it); // [R1]
			end
			if (r_r.it == CORDIC_LAST) begin
				r_nxt.busy = 1'b0;
				r_nxt.done = 1'b1;
			end else begin
				r_nxt.it = r_r.it + 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign o_done = r_r.done;
	assign o_angle = r_r.z;

	// ==========================================================
	// Checks
	atan_latency_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		i_start && !r_r.busy |-> ##17 o_done) else $error("arctangent result late or early"); // [R1]
endmodule // pcd_atan

`default_nettype wire

// *** design/pcd_top.sv ***
// Purpose: Coil offset compensation, arctangent, calibration and linearization
// Assumes: Raw channel samples come from logic on the same clock
// Notes:   One sample in flight; new samples are taken only while idle
//
// The implementer's own choice: the plain strobed port.
`default_nettype none

module pcd_top (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// Register port
	input wire logic [pcd_pkg::AW-1:0] i_addr,
	input wire logic [pcd_pkg::DW-1:0] i_wdata,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	output logic [pcd_pkg::DW-1:0] o_rdata,
	// Receiver samples
	input wire logic i_smp_vld,
	input wire pcd_pkg::pcd_raw_s i_raw,
	output logic o_smp_ready,
	// Position results
	output logic o_pos_vld,
	output logic [pcd_pkg::DW-1:0] o_spa,
	output logic [pcd_pkg::DW-1:0] o_calibrated_position,
	output logic [pcd_pkg::DW-1:0] o_linearized_position
);
	import pcd_pkg::*;

	pcd_main_s r_r;
	pcd_main_s r_nxt;
	logic atan_start;
	logic atan_done;
	logic [DW-1:0] atan_angle;
	logic signed [DW:0] comp_sin;
	logic signed [DW:0] comp_cos;
	logic signed [21:0] ofs_v;
	logic signed [21:0] ofs_eff;
	logic signed [21:0] diff;
	logic [SLOPE_MAG_W-1:0] slope_mag;
	logic signed [35:0] prod;
	logic [DW-1:0] cal_nxt;
	logic [2:0] seg;
	logic [SEG_SH-1:0] frac;
	logic signed [7:0] c_lo;
	logic signed [7:0] c_hi;
	logic signed [8:0] c_delta;
	logic signed [24:0] term;
	logic signed [24:0] corr_cnt;
	logic signed [35:0] lin_sum;
	logic [DW-1:0] lin_nxt;

	// ==========================================================
	// Helpers
	// Limits a written word to a symmetric signed range
	function automatic logic signed [DW-1:0] sat_sym(input logic [DW-1:0] w, input logic signed [DW-1:0] lim);
		logic signed [DW-1:0] s;
		s = $signed(w);
		if (s > lim) begin
			s = lim;
		end else if (s < -lim) begin
			s = -lim;
		end
		return s;
	endfunction

	// Clips a wide signed result into the unsigned position range
	function automatic logic [DW-1:0] sat_pos(input logic signed [35:0] v);
		if (v < 0) begin
			return '0;
		end else if (v > POS_MAX) begin
			return '1;
		end
		return v[DW-1:0];
	endfunction

	// Address decode for the correction table, shared by write and read
	function automatic logic is_corr(input logic [AW-1:0] a);
		return (a >= ADR_CORR_FIRST) && (a <= ADR_CORR_LAST);
	endfunction

	function automatic logic [3:0] corr_idx(input logic [AW-1:0] a);
		return 4'(a - ADR_CORR_FIRST);
	endfunction

	// ==========================================================
	// Arctangent engine
	// Coil offsets come off before the angle, so the angle never sees them
	assign comp_sin = 17'(i_raw.sin) - 17'(r_r.coil_sin); // [R4]
	assign comp_cos = 17'(i_raw.cos) - 17'(r_r.coil_cos); // [R4]

	// One angle engine, shared by every sample; a new sample waits for idle
	pcd_atan i_pcd_atan (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_start(atan_start),
		.i_x(comp_cos),
		.i_y(comp_sin),
		.o_done(atan_done),
		.o_angle(atan_angle)
	);

	// ==========================================================
	// Zero offset and slope
	// Offset word decode: above the 8192 base the offset lies below half scale
	always_comb begin
		if (r_r.zero_ofs[ZO_SEL_BIT]) begin
			ofs_v = HALF_SCALE - $signed(22'(r_r.zero_ofs[ZO_SEL_BIT-1:0]) << ZO_SCALE_SH); // [R9]
		end else begin
			ofs_v = HALF_SCALE + $signed(22'(r_r.zero_ofs[ZO_SEL_BIT-1:0]) << ZO_SCALE_SH); // [R9]
		end
		// Wraparound mode moves the neutral word to zero
		ofs_eff = r_r.wrap ? (ofs_v + HALF_SCALE) : ofs_v; // [R8]
		// Inverted polarity measures back from the maximum angle
		if (r_r.slope[SLOPE_INV_BIT]) begin
			diff = ofs_eff - $signed(22'(r_r.spa)); // [R11]
		end else begin
			diff = $signed(22'(r_r.spa)) - ofs_eff; // [R2]
		end
		// In wraparound mode the difference wraps round the turn
		if (r_r.wrap) begin
			diff = $signed(22'(diff[DW-1:0]));
		end
	end

	// Magnitude field is twelve bits, so the factor stays under four
	assign slope_mag = r_r.slope[SLOPE_MAG_W-1:0]; // [R3]
	assign prod = diff * $signed({1'b0, slope_mag}); // [R2]
	assign cal_nxt = sat_pos(prod >>> SLOPE_FRAC); // [R10] [R16]

	// ==========================================================
	// Piecewise-linear correction
	// Segment from the top bits, position inside it from the rest
	assign seg = r_r.cal[DW-1:SEG_SH]; // [R12]
	assign frac = r_r.cal[SEG_SH-1:0];
	assign c_lo = $signed(r_r.corr[seg]);
	assign c_hi = $signed(r_r.corr[4'(seg) + 4'h1]);
	assign c_delta = 9'(c_hi) - 9'(c_lo);
	// Interpolated factor times 8192, computed in one step to keep the fraction
	assign term = ($signed(25'(c_lo)) <<< SEG_SH) + 25'(c_delta) * $signed({1'b0, frac}); // [R15]
	assign corr_cnt = term >>> (SEG_SH - CORR_SCALE_SH); // [R13]
	assign lin_sum = $signed(36'(r_r.cal)) + 36'(corr_cnt);
	assign lin_nxt = sat_pos(lin_sum); // [R16]

	// ==========================================================
	// Register access and sequencing
	always_comb begin
		r_nxt = r_r;
		r_nxt.vld = 1'b0;
		r_nxt.rdata = '0;
		atan_start = 1'b0;
		// Writes; limited fields are clipped on the way in
		if (i_wr_en) begin
			case (i_addr)
				ADR_ZERO_OFS: r_nxt.zero_ofs = i_wdata; // [R8]
				ADR_SLOPE: r_nxt.slope = i_wdata; // [R10]
				ADR_COIL_SIN: r_nxt.coil_sin = 9'(sat_sym(i_wdata, COIL_MAX)); // [R4]
				ADR_COIL_COS: r_nxt.coil_cos = 9'(sat_sym(i_wdata, COIL_MAX)); // [R4]
				ADR_MODE: r_nxt.wrap = i_wdata[MODE_WRAP_BIT];
				default: ;
			endcase
			if (is_corr(i_addr)) begin
				r_nxt.corr[corr_idx(i_addr)] = 8'(sat_sym(i_wdata, CORR_MAX)); // [R14]
			end
		end
		// Reads answer in the next cycle only; unmapped reads give zero
		if (i_rd_en) begin
			case (i_addr)
				ADR_ZERO_OFS: r_nxt.rdata = r_r.zero_ofs;
				ADR_SLOPE: r_nxt.rdata = r_r.slope;
				ADR_COIL_SIN: r_nxt.rdata = DW'(r_r.coil_sin);
				ADR_COIL_COS: r_nxt.rdata = DW'(r_r.coil_cos);
				ADR_MODE: r_nxt.rdata = DW'(r_r.wrap);
				ADR_RAW_SIN: r_nxt.rdata = r_r.raw.sin; // [R5]
				ADR_RAW_COS: r_nxt.rdata = r_r.raw.cos; // [R5]
				ADR_SPA: r_nxt.rdata = r_r.spa;
				ADR_CAL: r_nxt.rdata = r_r.cal;
				ADR_LIN: r_nxt.rdata = r_r.lin;
				ADR_STATUS: r_nxt.rdata = DW'(r_r.st != ST_IDLE);
				default: r_nxt.rdata = '0;
			endcase
			if (is_corr(i_addr)) begin
				r_nxt.rdata = DW'($signed(r_r.corr[corr_idx(i_addr)]));
			end
		end
		// Calibration strictly before correction, one stage per cycle
		unique case (r_r.st)
			ST_IDLE: begin
				if (i_smp_vld) begin
					r_nxt.raw = i_raw; // [R5]
					atan_start = 1'b1; // [R1]
					r_nxt.st = ST_ATAN;
				end
			end
			ST_ATAN: begin
				if (atan_done) begin
					r_nxt.spa = atan_angle; // [R1]
					r_nxt.st = ST_CAL;
				end
			end
			ST_CAL: begin
				r_nxt.cal = cal_nxt; // [R6]
				r_nxt.st = ST_LIN;
			end
			ST_LIN: begin
				r_nxt.lin = lin_nxt; // [R6]
				r_nxt.vld = 1'b1;
				r_nxt.st = ST_IDLE;
			end
			default: r_nxt.st = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			r_r <= MAIN_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ==========================================================
	// Outputs
	// Ready is combinational so a sample can be offered in the idle cycle
	assign o_smp_ready = (r_r.st == ST_IDLE);
	assign o_rdata = r_r.rdata;
	assign o_pos_vld = r_r.vld;
	assign o_spa = r_r.spa;
	assign o_calibrated_position = r_r.cal;
	assign o_linearized_position = r_r.lin;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);

	logic neutral_cfg;
	logic coil_over;
	logic coil_under;
	logic corr_over;
	logic corr_under;
	logic [DW-1:0] point_exp;
	assign neutral_cfg = (r_r.zero_ofs == ZERO_OFS_RST) && (r_r.slope == SLOPE_RST) && !r_r.wrap && (r_r.corr == '0);

	// Written words beyond the limits, seen as the master offers them
	assign coil_over = i_wr_en && (i_addr == ADR_COIL_SIN) && ($signed(i_wdata) > COIL_MAX);
	assign coil_under = i_wr_en && (i_addr == ADR_COIL_SIN) && ($signed(i_wdata) < -COIL_MAX);
	assign corr_over = i_wr_en && is_corr(i_addr) && ($signed(i_wdata) > CORR_MAX);
	assign corr_under = i_wr_en && is_corr(i_addr) && ($signed(i_wdata) < -CORR_MAX);

	// At a correction point the whole factor applies, scaled by 32
	assign point_exp = sat_pos($signed(36'(r_r.cal)) + (36'(c_lo) <<< CORR_SCALE_SH));

	state_onehot_a: assert property ($onehot(r_r.st))
		else $error("sequencer state not one-hot");
	atan_to_cal_a: assert property (r_r.st == ST_ATAN && atan_done |=> r_r.st == ST_CAL ##1 r_r.st == ST_LIN) // [R6]
		else $error("calibration did not follow the angle");
	cal_then_lin_a: assert property (r_r.st == ST_LIN |=> o_pos_vld && $stable(o_calibrated_position)) // [R6]
		else $error("linearized result not published after calibration");
	sample_latency_a: assert property (i_smp_vld && o_smp_ready |-> ##20 o_pos_vld) // [R1]
		else $error("position result not twenty cycles after sample");
	neutral_pass_a: assert property (r_r.st == ST_CAL && neutral_cfg |=> o_calibrated_position == o_spa) // [R7]
		else $error("neutral calibration changed the angle");
	neutral_lin_a: assert property (r_r.st == ST_LIN && neutral_cfg |=> o_linearized_position == o_calibrated_position) // [R7]
		else $error("zero corrections changed the position");
	coil_limit_a: assert property (r_r.coil_sin <= 9'sd252 && r_r.coil_sin >= -9'sd252 && r_r.coil_cos <= 9'sd252 && r_r.coil_cos >= -9'sd252) // [R4]
		else $error("coil compensation beyond 252");
	corr_limit_a: assert property (i_wr_en && is_corr(i_addr) |=> $signed(r_r.corr[corr_idx($past(i_addr))]) >= -8'sd127) // [R14]
		else $error("correction factor below minus 127");
	corr_span_a: assert property (o_pos_vld |-> ($signed({1'b0, o_linearized_position}) - $signed({1'b0, o_calibrated_position}) <= 17'sd4064) && ($signed({1'b0, o_calibrated_position}) - $signed({1'b0, o_linearized_position}) <= 17'sd4064)) // [R13]
		else $error("correction larger than 127 units of 32");
	raw_read_a: assert property (i_rd_en && i_addr == ADR_RAW_SIN |=> o_rdata == $past(r_r.raw.sin)) // [R5]
		else $error("raw sine readback wrong");
	read_once_a: assert property (!i_rd_en |=> o_rdata == '0)
		else $error("read data outside the answer cycle");

	// Register port: a write lands in the next cycle, a read shows the old word
	wr_zero_a: assert property (i_wr_en && i_addr == ADR_ZERO_OFS |=> r_r.zero_ofs == $past(i_wdata)) // [R8]
		else $error("zero offset write lost");
	wr_slope_a: assert property (i_wr_en && i_addr == ADR_SLOPE |=> r_r.slope == $past(i_wdata)) // [R10]
		else $error("slope write lost");
	wr_mode_a: assert property (i_wr_en && i_addr == ADR_MODE |=> r_r.wrap == $past(i_wdata[MODE_WRAP_BIT])) // [R8]
		else $error("mode write lost");
	rd_zero_a: assert property (i_rd_en && i_addr == ADR_ZERO_OFS |=> o_rdata == $past(r_r.zero_ofs)) // [R8]
		else $error("zero offset readback wrong");
	rd_slope_a: assert property (i_rd_en && i_addr == ADR_SLOPE |=> o_rdata == $past(r_r.slope)) // [R10]
		else $error("slope readback wrong");
	rd_raw_cos_a: assert property (i_rd_en && i_addr == ADR_RAW_COS |=> o_rdata == $past(r_r.raw.cos)) // [R5]
		else $error("raw cosine readback wrong");

	// Clipping on the way in; out-of-range words must not wrap
	coil_clip_hi_a: assert property (coil_over |=> r_r.coil_sin == 9'(COIL_MAX)) // [R4]
		else $error("coil compensation not clipped high");
	coil_clip_lo_a: assert property (coil_under |=> r_r.coil_sin == -9'(COIL_MAX)) // [R4]
		else $error("coil compensation not clipped low");
	corr_clip_hi_a: assert property (corr_over |=> $signed(r_r.corr[corr_idx($past(i_addr))]) == 8'(CORR_MAX)) // [R14]
		else $error("correction factor not clipped high");
	corr_clip_lo_a: assert property (corr_under |=> $signed(r_r.corr[corr_idx($past(i_addr))]) == -8'(CORR_MAX)) // [R14]
		else $error("correction factor not clipped low");

	// Sample handshake and result pulse
	take_busy_a: assert property (i_smp_vld && o_smp_ready |=> !o_smp_ready) // [R1]
		else $error("sequencer still ready after taking a sample");
	raw_take_a: assert property (i_smp_vld && o_smp_ready |=> r_r.raw == $past(i_raw)) // [R5]
		else $error("taken sample not captured");
	vld_pulse_a: assert property (o_pos_vld |=> !o_pos_vld)
		else $error("result pulse longer than one cycle");
	ready_back_a: assert property (o_pos_vld |-> o_smp_ready)
		else $error("not ready with the result");
	spa_take_a: assert property (r_r.st == ST_ATAN && atan_done |=> o_spa == $past(atan_angle)) // [R1]
		else $error("spatial angle not taken from the engine");

	// Full factor at a correction point, with nothing interpolated
	seg_point_a: assert property (r_r.st == ST_LIN && frac == '0 |=> o_linearized_position == $past(point_exp)) // [R12]
		else $error("correction point value wrong");

	result_cov: cover property (o_pos_vld);
	wrap_cov: cover property (o_pos_vld && r_r.wrap);
	invert_cov: cover property (o_pos_vld && r_r.slope[SLOPE_INV_BIT]);
	saturate_cov: cover property (o_pos_vld && o_linearized_position == 16'hffff);
	point_cov: cover property (r_r.st == ST_LIN && frac == '0 && c_lo != '0);
endmodule // pcd_top

`default_nettype wire

// *** verif/pcd_src.sv ***
// Purpose: Receiver front end model offering sine and cosine samples
// Assumes: One sample per request, held until the block takes it
// Notes:   Released data lines are inverted so stale values never look valid
`default_nettype none

module pcd_src (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// Bench control
	input wire logic i_go,
	input wire logic [3:0] i_lag,
	input wire pcd_pkg::pcd_raw_s i_val,
	// Sample handshake
	input wire logic i_smp_ready,
	output logic o_smp_vld,
	output pcd_pkg::pcd_raw_s o_raw
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pend_r;
	logic [3:0] cnt_r;

	// ==========================================================
	// Offer after a lag, hold until taken, then scramble the lines
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_smp_vld <= 1'b0;
			o_raw <= '0;
			pend_r <= 1'b0;
			cnt_r <= '0;
		end else if (i_go) begin
			pend_r <= 1'b1;
			cnt_r <= i_lag;
		end else if (o_smp_vld) begin
			if (i_smp_ready) begin
				o_smp_vld <= 1'b0;
				o_raw <= ~o_raw;
			end
		end else if (pend_r) begin
			if (cnt_r == 4'h0) begin
				o_smp_vld <= 1'b1;
				o_raw <= i_val;
				pend_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule // pcd_src

`default_nettype wire

// *** verif/pcd_top_bench.sv ***
// Purpose: Self-checking bench of the position calibration datapath
// Assumes: Angle results may differ by a few counts from the ideal arctangent
// Notes:   Expected positions are worked out from ideal angles, so checks carry a tolerance
`default_nettype none

module pcd_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import pcd_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [DW-1:0] rdata;
	logic smp_vld;
	pcd_raw_s raw;
	pcd_raw_s val = '0;
	logic smp_ready;
	logic pos_vld;
	logic [DW-1:0] spa;
	logic [DW-1:0] cal;
	logic [DW-1:0] lin;
	logic go = 1'b0;
	logic [3:0] lag = '0;
	logic [DW-1:0] d;
	int err_count = 0;
	int n_tests = 0;

	// ==========================================================
	// Clock, design and sample source
	always #25 clk_sys = ~clk_sys;

	pcd_top i_pcd_top (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
		.i_wr_en(wr_en), .i_rd_en(rd_en), .o_rdata(rdata), .i_smp_vld(smp_vld), .i_raw(raw),
		.o_smp_ready(smp_ready), .o_pos_vld(pos_vld), .o_spa(spa), .o_calibrated_position(cal),
		.o_linearized_position(lin));

	pcd_src i_pcd_src (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_go(go), .i_lag(lag), .i_val(val),
		.i_smp_ready(smp_ready), .o_smp_vld(smp_vld), .o_raw(raw));

	// ==========================================================
	// Shared tasks
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Tolerance covers the arctangent quantisation; zero means exact
	task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp, input int tol);
		n_tests++;
		if (^seen === 1'bx || (seen > exp ? seen - exp : exp - seen) > tol) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(negedge clk_sys);
		v = rdata;
	endtask

	// Offer one sample and wait for its result, timing the answer
	task automatic meas(input logic [DW-1:0] s, input logic [DW-1:0] c, input logic [3:0] l);
		int n;
		@(posedge clk_sys);
		val <= '{sin: s, cos: c};
		lag <= l;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (!(smp_vld && smp_ready) && n < 100);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			@(negedge clk_sys);
		end while (pos_vld !== 1'b1 && n < 40);
		chk(16'(n), 16'h0014, 0); // Result twenty cycles after take
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rd(ADR_ZERO_OFS, d);
		chk(d, 16'h2400, 0); // Neutral offset
		rd(ADR_SLOPE, d);
		chk(d, 16'h0400, 0); // Unity slope
		rd(5'h1f, d);
		chk(d, 16'h0000, 0);
	endtask

	task automatic t_neutral;
		meas(16'h1b9f, 16'h1b9f, 4'h3);
		chk(spa, 16'h2000, 8); // Eighth turn
		chk(cal, 16'h2000, 8); // Unchanged
		chk(lin, 16'h2000, 8); // Unchanged
		rd(ADR_RAW_SIN, d);
		chk(d, 16'h1b9f, 0); // Raw sine
	endtask

	task automatic t_coil;
		wr(ADR_COIL_SIN, 16'h012c);
		rd(ADR_COIL_SIN, d);
		chk(d, 16'h00fc, 0); // Clipped
		wr(ADR_COIL_SIN, 16'hfed4);
		rd(ADR_COIL_SIN, d);
		chk(d, 16'hff04, 0); // Clipped
		wr(ADR_COIL_SIN, 16'h0000);
		wr(ADR_COIL_COS, 16'h00c8);
		meas(16'h2710, 16'h00c8, 4'h0);
		chk(spa, 16'h4000, 8); // Quarter turn once cosine is cleared
		rd(ADR_RAW_COS, d);
		chk(d, 16'h00c8, 0); // Uncompensated
		wr(ADR_COIL_COS, 16'h0000);
	endtask

	task automatic t_calib;
		wr(ADR_ZERO_OFS, 16'h2300);
		meas(16'h2710, 16'h0000, 4'h0);
		chk(cal, 16'h2000, 8); // Offset of an eighth
		meas(16'h0ef3, 16'h2417, 4'h0);
		chk(cal, 16'h0000, 0); // Below zero
		wr(ADR_ZERO_OFS, 16'h2400);
		wr(ADR_SLOPE, 16'h0800);
		meas(16'h0ef3, 16'h2417, 4'h1);
		chk(cal, 16'h2000, 16); // Doubled
		meas(16'hd8f0, 16'h0000, 4'h0);
		chk(cal, 16'hffff, 0); // Above full scale
		wr(ADR_SLOPE, 16'h0fff);
		meas(16'h0ef3, 16'h2417, 4'h0);
		chk(cal, 16'h3ffc, 32); // Largest slope
		wr(ADR_ZERO_OFS, 16'h0200);
		wr(ADR_SLOPE, 16'h1400);
		meas(16'h0ef3, 16'h2417, 4'h0);
		chk(cal, 16'hb000, 8); // Reversed from the top reference
		wr(ADR_SLOPE, 16'h0400);
		wr(ADR_ZERO_OFS, 16'h0000);
		wr(ADR_MODE, 16'h0001);
		meas(16'h2710, 16'h0000, 4'h0);
		chk(cal, 16'h4000, 8); // Wraparound neutral
		wr(ADR_MODE, 16'h0000);
		wr(ADR_ZERO_OFS, 16'h2400);
	endtask

	task automatic t_lin;
		wr(ADR_CORR_FIRST + 5'h01, 16'h00c8);
		rd(ADR_CORR_FIRST + 5'h01, d);
		chk(d, 16'h007f, 0); // Clipped
		wr(ADR_CORR_FIRST + 5'h01, 16'hff80);
		rd(ADR_CORR_FIRST + 5'h01, d);
		chk(d, 16'hff81, 0); // Clipped
		wr(ADR_CORR_FIRST + 5'h01, 16'h0014);
		meas(16'h0ef3, 16'h2417, 4'h2);
		chk(cal, 16'h1000, 8); // Before correction
		chk(lin, 16'h1140, 8); // Half way between points
		wr(ADR_CORR_FIRST + 5'h01, 16'hffec);
		meas(16'h0ef3, 16'h2417, 4'h0);
		chk(lin, 16'h0ec0, 8); // Negative factor
		meas(16'h1b9f, 16'h1b9f, 4'h0);
		chk(lin, 16'h1d80, 8); // Full factor at a point
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_neutral();
		t_coil();
		t_calib();
		t_lin();
		end_sim();
	end

	// Twelve results and 36 comparisons are expected; a hang runs far past that
	initial begin
		#1ms;
		err_count++;
		end_sim();
	end
endmodule // pcd_top_bench

`default_nettype wire
